// ===== hw/cit_core.sv
// Core sequencer: interrupt timing, stack, data-space decode, stalls
// How it works
// - Interrupt entry takes at least four cycles.
// - Entry pushes program counter onto the stack.
// - Vector jump takes three cycles.
// - Multi-cycle instruction finishes before interrupt entry.
// - Wake from sleep adds four entry cycles.
// - Return: four cycles, pop counter, enable interrupts.
// - One instruction runs after enable before interrupts.
// - Program memory 4K words, 12-bit counter.
// - Data space: registers, I/O, extended, SRAM.
// - Extended I/O only via load/store instructions.
// - Displacement reaches 63 beyond Y or Z.
// - Pre-decrement and post-increment update the pointer.
// - SRAM access completes in two cycles.
// - 512-byte nonvolatile store, byte access.
// - Store registers sit in standard I/O space.
// - Store read stalls four cycles.
// - Store write stalls two cycles.
// - Writes need arm sequence; completion self-timed.
// - Interrupt entry clears global interrupt enable.
// - Arm bit clears four cycles after set.
`timescale 1ns/100ps
module cit_core
  import cit_pkg::*;
#(
  parameter int NV_WRITE_CYCLES = NV_WRITE_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic op_valid,
  input cit_op_s op,
  output logic op_ready,
  input wire logic irq_pending,
  input wire logic [PC_W-1:0] irq_vector,
  input wire logic wake_ready,
  input wire logic [7:0] ext_rdata,
  output logic irq_ack_ff,
  output logic [PC_W-1:0] pc_ff,
  output logic [15:0] sp_ff,
  output logic gie_ff,
  output logic sleeping,
  output logic stalled,
  output cit_dacc_s dacc_ff,
  output logic [7:0] rd_data_ff,
  output logic rd_valid_ff,
  output logic nv_busy
);
  cit_state_e state_ff;
  cit_state_e nxt_state;
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic shadow_ff;
  logic [15:0] ptr_ff [0:2];
  logic [7:0] sram_mem [0:SRAM_SIZE-1];
  logic irq_take;
  logic accept;
  logic is_mem_op;
  logic [15:0] base;
  logic [15:0] eff_addr;
  cit_region_e eff_region;
  logic [8:0] push_idx;
  logic [8:0] pop_idx;
  logic [8:0] dacc_idx;
  logic mem_cyc;
  logic nv_we;
  logic [5:0] nv_idx;
  logic [7:0] nv_rdata;
  logic nv_rd_trig;
  logic nv_wr_trig;

  function automatic cit_region_e decode(input logic [15:0] a);
    if (a < IO_BASE) return RG_REGF;
    else if (a < EXT_BASE) return RG_IO;
    else if (a < SRAM_BASE) return RG_EXT;
    else if (a <= SRAM_END) return RG_SRAM;
    else return RG_NONE;
  endfunction : decode

  // Interrupts are looked at only between instructions
  assign irq_take = (state_ff == ST_IDLE) && irq_pending && gie_ff && !shadow_ff;
  assign op_ready = (state_ff == ST_IDLE) && !irq_take;
  assign accept = op_valid && op_ready;
  assign is_mem_op = (op.op == OP_LD) || (op.op == OP_ST) || (op.op == OP_IN) || (op.op == OP_OUT);
  assign sleeping = (state_ff == ST_SLEEP);
  assign stalled = (state_ff == ST_STALL);

  // Effective address generation
  always_comb begin
    base = ptr_ff[op.ptr];
    eff_addr = op.addr;
    unique case (op.amode)
      AM_DIRECT: eff_addr = op.addr;
      AM_IND: eff_addr = base;
      AM_DISP: eff_addr = base + {10'h000, op.disp};
      AM_PREDEC: eff_addr = base - 16'h0001;
      AM_POSTINC: eff_addr = base;
      default: eff_addr = op.addr;
    endcase
    // Short I/O form carries only six index bits, so it stops below 0x60
    if (op.op == OP_IN || op.op == OP_OUT) eff_addr = IO_BASE + {10'h000, op.addr[5:0]};
    eff_region = decode(eff_addr);
  end

  assign push_idx = 9'(sp_ff - SRAM_BASE);
  assign pop_idx = 9'(sp_ff + 16'h0001 - SRAM_BASE);
  assign dacc_idx = 9'(dacc_ff.addr - SRAM_BASE);
  assign mem_cyc = (state_ff == ST_MEM);
  assign nv_we = mem_cyc && dacc_ff.we && (dacc_ff.region == RG_IO);
  assign nv_idx = 6'(dacc_ff.addr - IO_BASE);

  cit_nvm #(
    .WRITE_CYC(NV_WRITE_CYCLES)
  ) u_nvm (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .io_we(nv_we),
    .io_idx(nv_idx),
    .io_wdata(dacc_ff.wdata),
    .io_rdata(nv_rdata),
    .rd_trig(nv_rd_trig),
    .wr_trig(nv_wr_trig),
    .busy(nv_busy)
  );

  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (irq_take) begin
          nxt_state = ST_IRQ;
          nxt_cnt = IRQ_ENTRY_CYC - 3'h1;
        end else if (accept) begin
          unique case (op.op)
            OP_MULTI: begin
              if (op.extra != 2'h0) begin
                nxt_state = ST_EXEC;
                nxt_cnt = {1'b0, op.extra} - 3'h1;
              end
            end
            OP_SLEEP: nxt_state = ST_SLEEP;
            OP_RETI: begin
              nxt_state = ST_RETI;
              nxt_cnt = RETI_CYC - 3'h2;
            end
            OP_JMP: begin
              nxt_state = ST_JMP;
              nxt_cnt = JMP_CYC - 3'h2;
            end
            OP_LD, OP_ST, OP_IN, OP_OUT: begin
              nxt_state = ST_MEM;
              nxt_cnt = SRAM_CYC - 3'h2;
            end
            default: nxt_state = ST_IDLE;
          endcase
        end
      end
      ST_MEM: begin
        if (nv_rd_trig) begin
          nxt_state = ST_STALL;
          nxt_cnt = EE_RD_STALL - 3'h1;
        end else if (nv_wr_trig) begin
          nxt_state = ST_STALL;
          nxt_cnt = EE_WR_STALL - 3'h1;
        end else begin
          nxt_state = ST_IDLE;
        end
      end
      ST_SLEEP: begin
        if (wake_ready && irq_pending && gie_ff) begin
          nxt_state = ST_WAKE;
          nxt_cnt = WAKE_EXTRA_CYC - 3'h1;
        end
      end
      ST_WAKE: begin
        nxt_cnt = cnt_ff - 3'h1;
        if (cnt_ff == 3'h0) begin
          nxt_state = ST_IRQ;
          nxt_cnt = IRQ_ENTRY_CYC - 3'h1;
        end
      end
      ST_EXEC, ST_IRQ, ST_RETI, ST_JMP, ST_STALL: begin
        nxt_cnt = cnt_ff - 3'h1;
        if (cnt_ff == 3'h0) nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // Global enable
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gie_ff <= 1'b0;
    end else if (state_ff == ST_IRQ && cnt_ff == 3'h0) begin
      gie_ff <= 1'b0;
    end else if (state_ff == ST_RETI && cnt_ff == 3'h0) begin
      gie_ff <= 1'b1;
    end else if (accept && op.op == OP_SEI) begin
      gie_ff <= 1'b1;
    end else if (accept && op.op == OP_CLI) begin
      gie_ff <= 1'b0;
    end
  end

  // One-instruction shadow after enabling or returning
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shadow_ff <= 1'b0;
    end else if (state_ff == ST_RETI && cnt_ff == 3'h0) begin
      shadow_ff <= 1'b1;
    end else if (accept) begin
      shadow_ff <= (op.op == OP_SEI);
    end
  end

  // Program counter
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_ff <= '0;
    end else begin
      if (accept) pc_ff <= pc_ff + 12'h001;
      if (state_ff == ST_IRQ && cnt_ff == 3'h0) pc_ff <= irq_vector;
      if (state_ff == ST_JMP && cnt_ff == 3'h0) pc_ff <= dacc_ff.addr[PC_W-1:0];
      if (state_ff == ST_RETI && cnt_ff == 3'h1) pc_ff[11:8] <= sram_mem[pop_idx][3:0];
      if (state_ff == ST_RETI && cnt_ff == 3'h0) pc_ff[7:0] <= sram_mem[pop_idx];
    end
  end

  // Entry done pulse, one cycle with the vector in place
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ack_ff <= 1'b0;
    end else begin
      irq_ack_ff <= (state_ff == ST_IRQ && cnt_ff == 3'h0);
    end
  end

  // Stack pointer: push lowers it, pop raises it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_ff <= SP_RESET;
    end else if (state_ff == ST_IRQ && cnt_ff >= 3'h2) begin
      sp_ff <= sp_ff - 16'h0001;
    end else if (state_ff == ST_RETI && cnt_ff <= 3'h1) begin
      sp_ff <= sp_ff + 16'h0001;
    end
  end

  // Stack pushes and data stores into SRAM
  always_ff @(posedge ref_clk) begin
    if (state_ff == ST_IRQ && cnt_ff == 3'h3) sram_mem[push_idx] <= pc_ff[7:0];
    if (state_ff == ST_IRQ && cnt_ff == 3'h2) sram_mem[push_idx] <= {4'h0, pc_ff[11:8]};
    if (mem_cyc && dacc_ff.we && dacc_ff.region == RG_SRAM) begin
      sram_mem[dacc_idx] <= dacc_ff.wdata;
    end
  end

  // Access record; also holds the jump target
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dacc_ff <= '0;
    end else if (accept && is_mem_op) begin
      dacc_ff.valid <= 1'b1;
      dacc_ff.we <= (op.op == OP_ST) || (op.op == OP_OUT);
      dacc_ff.region <= eff_region;
      dacc_ff.addr <= eff_addr;
      dacc_ff.wdata <= op.wdata;
    end else if (accept && op.op == OP_JMP) begin
      dacc_ff <= '0;
      dacc_ff.addr <= op.addr;
    end else begin
      dacc_ff.valid <= 1'b0;
    end
  end

  // Pointer registers: mode updates at issue, register-file stores later
  for (genvar g = 0; g < 3; g++) begin : g_ptr
    logic mode_hit;
    logic reg_hit;
    assign mode_hit = accept && (op.op == OP_LD || op.op == OP_ST) && (int'(op.ptr) == g);
    assign reg_hit = mem_cyc && dacc_ff.we && dacc_ff.region == RG_REGF &&
                     dacc_ff.addr >= PTR_REG_BASE && (dacc_ff.addr[2:1] == 2'(g + 1));
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        ptr_ff[g] <= 16'h0000;
      end else if (mode_hit && op.amode == AM_PREDEC) begin
        ptr_ff[g] <= base - 16'h0001;
      end else if (mode_hit && op.amode == AM_POSTINC) begin
        ptr_ff[g] <= base + 16'h0001;
      end else if (reg_hit && dacc_ff.addr[0]) begin
        ptr_ff[g][15:8] <= dacc_ff.wdata;
      end else if (reg_hit) begin
        ptr_ff[g][7:0] <= dacc_ff.wdata;
      end
    end
  end

  // Read strobe, paired with the data below
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= mem_cyc && !dacc_ff.we;
    end
  end

  // Read data at the end of the second access cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= 8'h00;
    end else begin
      if (mem_cyc && !dacc_ff.we) begin
        unique case (dacc_ff.region)
          RG_SRAM: rd_data_ff <= sram_mem[dacc_idx];
          RG_IO: begin
            if (nv_idx >= NV_CTRL_IDX && nv_idx <= NV_ADRH_IDX) rd_data_ff <= nv_rdata;
            else rd_data_ff <= ext_rdata;
          end
          RG_REGF, RG_EXT: rd_data_ff <= ext_rdata;
          default: rd_data_ff <= 8'h00;
        endcase
      end
    end
  end
endmodule : cit_core

// ===== hw/cit_pkg.sv
// Shared constants and types for the core timing and data-space block
package cit_pkg;
  // Program memory and program counter
  localparam int PC_W = 12;
  localparam int PMEM_WORDS = 4096;
  localparam int PMEM_W = 16;
  // Data-space map
  localparam logic [15:0] REGF_BASE = 16'h0000;
  localparam logic [15:0] IO_BASE = 16'h0020;
  localparam logic [15:0] EXT_BASE = 16'h0060;
  localparam logic [15:0] SRAM_BASE = 16'h0100;
  localparam logic [15:0] SRAM_END = 16'h02FF;
  localparam int REGF_SIZE = 32;
  localparam int IO_SIZE = 64;
  localparam int EXT_SIZE = 160;
  localparam int SRAM_SIZE = 512;
  localparam logic [15:0] PTR_REG_BASE = 16'h001A;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam int DISP_MAX = 63;
  // Cycle counts
  localparam logic [2:0] IRQ_ENTRY_CYC = 3'h4;
  localparam logic [2:0] WAKE_EXTRA_CYC = 3'h4;
  localparam logic [2:0] RETI_CYC = 3'h4;
  localparam logic [2:0] JMP_CYC = 3'h3;
  localparam logic [2:0] SRAM_CYC = 3'h2;
  localparam logic [2:0] EE_RD_STALL = 3'h4;
  localparam logic [2:0] EE_WR_STALL = 3'h2;
  localparam logic [2:0] ARM_WINDOW_CYC = 3'h4;
  // Nonvolatile store and its I/O registers
  localparam int NV_SIZE = 512;
  localparam int NV_AW = 9;
  localparam logic [5:0] NV_CTRL_IDX = 6'h1F;
  localparam logic [5:0] NV_DATA_IDX = 6'h20;
  localparam logic [5:0] NV_ADRL_IDX = 6'h21;
  localparam logic [5:0] NV_ADRH_IDX = 6'h22;
  localparam int NVC_RD = 0;
  localparam int NVC_WR = 1;
  localparam int NVC_ARM = 2;
  localparam int CLK_PERIOD_PS = 4000;
  localparam longint NV_WRITE_TIME_PS = 64'd3_300_000_000;
  localparam int NV_WRITE_CYC = int'(NV_WRITE_TIME_PS / CLK_PERIOD_PS);

  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_MULTI = 4'h1, OP_SEI = 4'h2, OP_CLI = 4'h3,
    OP_SLEEP = 4'h4, OP_RETI = 4'h5, OP_JMP = 4'h6, OP_LD = 4'h7,
    OP_ST = 4'h8, OP_IN = 4'h9, OP_OUT = 4'hA
  } cit_op_e;
  typedef enum logic [2:0] {
    AM_DIRECT = 3'h0, AM_IND = 3'h1, AM_DISP = 3'h2, AM_PREDEC = 3'h3, AM_POSTINC = 3'h4
  } cit_amode_e;
  typedef enum logic [1:0] {PTR_X = 2'h0, PTR_Y = 2'h1, PTR_Z = 2'h2} cit_ptr_e;
  typedef enum logic [2:0] {
    RG_REGF = 3'h0, RG_IO = 3'h1, RG_EXT = 3'h2, RG_SRAM = 3'h3, RG_NONE = 3'h4
  } cit_region_e;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_EXEC = 4'h1, ST_MEM = 4'h2, ST_IRQ = 4'h3, ST_WAKE = 4'h4,
    ST_SLEEP = 4'h5, ST_RETI = 4'h6, ST_JMP = 4'h7, ST_STALL = 4'h8
  } cit_state_e;

  typedef struct packed {
    cit_op_e op;
    cit_amode_e amode;
    cit_ptr_e ptr;
    logic [1:0] extra;
    logic [5:0] disp;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cit_op_s;

  typedef struct packed {
    logic valid;
    logic we;
    cit_region_e region;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cit_dacc_s;
endpackage : cit_pkg

// ===== hw/cit_nvm.sv
// Byte-wide nonvolatile store with armed, self-timed writes
`timescale 1ns/100ps
module cit_nvm
  import cit_pkg::*;
#(
  parameter int WRITE_CYC = NV_WRITE_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic io_we,
  input wire logic [5:0] io_idx,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic rd_trig,
  output logic wr_trig,
  output logic busy
);
  logic [7:0] nv_mem [0:NV_SIZE-1];
  logic [NV_AW-1:0] addr_ff;
  logic [7:0] data_ff;
  logic nv_master_write_arm_ff;
  logic [2:0] arm_cnt_ff;
  logic busy_ff;
  logic [31:0] wcnt_ff;
  logic ctrl_we;

  assign ctrl_we = io_we && (io_idx == NV_CTRL_IDX);
  assign rd_trig = ctrl_we && io_wdata[NVC_RD] && !busy_ff;
  // Strobe without a live arm does nothing
  assign wr_trig = ctrl_we && io_wdata[NVC_WR] && nv_master_write_arm_ff && !busy_ff;
  assign busy = busy_ff;

  always_comb begin
    io_rdata = 8'h00;
    unique case (io_idx)
      NV_CTRL_IDX: io_rdata = {5'h00, nv_master_write_arm_ff, busy_ff, 1'b0};
      NV_DATA_IDX: io_rdata = data_ff;
      NV_ADRL_IDX: io_rdata = addr_ff[7:0];
      NV_ADRH_IDX: io_rdata = {7'h00, addr_ff[8]};
      default: io_rdata = 8'h00;
    endcase
  end

  // Address and data registers; address frozen while a write runs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_ff <= '0;
      data_ff <= 8'h00;
    end else begin
      if (io_we && !busy_ff && io_idx == NV_ADRL_IDX) addr_ff[7:0] <= io_wdata;
      if (io_we && !busy_ff && io_idx == NV_ADRH_IDX) addr_ff[8] <= io_wdata[0];
      if (rd_trig) begin
        data_ff <= nv_mem[addr_ff];
      end else if (io_we && io_idx == NV_DATA_IDX) begin
        data_ff <= io_wdata;
      end
    end
  end

  // Arm bit drops by itself after the window
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      nv_master_write_arm_ff <= 1'b0;
      arm_cnt_ff <= 3'h0;
    end else if (ctrl_we && io_wdata[NVC_ARM] && !io_wdata[NVC_WR]) begin
      nv_master_write_arm_ff <= 1'b1;
      arm_cnt_ff <= ARM_WINDOW_CYC - 3'h1;
    end else if (nv_master_write_arm_ff) begin
      if (arm_cnt_ff == 3'h0) nv_master_write_arm_ff <= 1'b0;
      arm_cnt_ff <= arm_cnt_ff - 3'h1;
    end
  end

  // Self-timed write; busy clears when the store is done
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      wcnt_ff <= 32'h0000_0000;
    end else if (wr_trig) begin
      busy_ff <= 1'b1;
      wcnt_ff <= 32'(WRITE_CYC - 1);
    end else if (busy_ff) begin
      if (wcnt_ff == 32'h0000_0000) busy_ff <= 1'b0;
      wcnt_ff <= wcnt_ff - 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (busy_ff && wcnt_ff == 32'h0000_0000) nv_mem[addr_ff] <= data_ff;
  end
endmodule : cit_nvm

// ===== bench/cit_core_assertions.sv
// Port-level timing checker for the core sequencer
`timescale 1ns/100ps
module cit_core_assertions
  import cit_pkg::*;
#(
  parameter int NV_WRITE_CYCLES = 20
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic op_valid,
  input wire cit_op_s op,
  input wire logic op_ready,
  input wire logic irq_pending,
  input wire logic [PC_W-1:0] irq_vector,
  input wire logic wake_ready,
  input wire logic [7:0] ext_rdata,
  input wire logic irq_ack_ff,
  input wire logic [PC_W-1:0] pc_ff,
  input wire logic [15:0] sp_ff,
  input wire logic gie_ff,
  input wire logic sleeping,
  input wire logic stalled,
  input wire cit_dacc_s dacc_ff,
  input wire logic [7:0] rd_data_ff,
  input wire logic rd_valid_ff,
  input wire logic nv_busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic take;
  logic sram_acc;
  assign take = op_valid && op_ready;
  assign sram_acc = take && (op.op == OP_LD || op.op == OP_ST) && op.amode == AM_DIRECT
    && op.addr >= SRAM_BASE && op.addr <= SRAM_END && !gie_ff;

  a_entry_busy: assert property (irq_ack_ff |-> !$past(op_ready, 1) && !$past(op_ready, 4))
    else $error("interrupt entry shorter than four cycles");
  a_entry_push: assert property (irq_ack_ff |-> sp_ff == $past(sp_ff, 6) - 16'h0002)
    else $error("return address not pushed");
  a_ack_vector: assert property (irq_ack_ff |-> pc_ff == irq_vector && !gie_ff)
    else $error("entry left wrong counter or enable");
  a_jump_time: assert property (take && op.op == OP_JMP && !gie_ff |=>
    !op_ready [*2] ##1 op_ready)
    else $error("jump not three cycles");
  a_multi_hold: assert property (take && op.op == OP_MULTI && op.extra == 2'h3 |=>
    !op_ready [*3])
    else $error("multi-cycle op cut short");
  a_reti_time: assert property (take && op.op == OP_RETI |=> !op_ready [*3] ##1
    (op_ready && gie_ff && sp_ff == $past(sp_ff, 4) + 16'h0002))
    else $error("return not four cycles");
  a_sei_next: assert property (take && op.op == OP_SEI |=> op_ready)
    else $error("op after enable not taken first");
  a_sram_time: assert property (sram_acc |=> !op_ready ##1 op_ready)
    else $error("sram access not two cycles");
  a_load_data: assert property (sram_acc && op.op == OP_LD |-> ##[1:2] rd_valid_ff)
    else $error("load data missing");
  a_nv_read: assert property (take && op.op == OP_OUT && op.addr[5:0] == NV_CTRL_IDX
    && op.wdata == 8'h01 && !nv_busy && !gie_ff |=> !op_ready [*5] ##1 op_ready)
    else $error("store read stall wrong");
  a_io_window: assert property (dacc_ff.valid && dacc_ff.region == RG_IO |->
    dacc_ff.addr >= IO_BASE && dacc_ff.addr < EXT_BASE)
    else $error("io region outside window");
endmodule : cit_core_assertions

// ===== bench/cit_core_test.sv
// Self-checking bench for the core sequencer
`timescale 1ns/100ps
module cit_core_test;
  import cit_pkg::*;
  localparam int NV_WRITE_CYCLES = 20;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic op_valid = 1'b0;
  cit_op_s op = '0;
  logic irq_pending = 1'b0;
  logic [PC_W-1:0] irq_vector = 12'h01C;
  logic wake_ready = 1'b1;
  logic [7:0] ext_rdata = 8'h00;
  logic op_ready, irq_ack_ff, gie_ff, sleeping, stalled, rd_valid_ff, nv_busy;
  logic [PC_W-1:0] pc_ff;
  logic [15:0] sp_ff;
  cit_dacc_s dacc_ff;
  logic [7:0] rd_data_ff;
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;
  int t_ack = 0;
  bit sleep_seen = 0;
  logic [15:0] last_addr;
  logic [31:0] seed = 32'h0000_73D9;
  logic [7:0] sram [int];
  logic [7:0] rdq [$];

  cit_core #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .op_valid(op_valid), .op(op), .op_ready(op_ready),
    .irq_pending(irq_pending), .irq_vector(irq_vector), .wake_ready(wake_ready),
    .ext_rdata(ext_rdata), .irq_ack_ff(irq_ack_ff), .pc_ff(pc_ff), .sp_ff(sp_ff),
    .gie_ff(gie_ff), .sleeping(sleeping), .stalled(stalled), .dacc_ff(dacc_ff),
    .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff), .nv_busy(nv_busy)
  );

  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic cit_region_e region_of(logic [15:0] a);
    if (a < 16'h0020) return RG_REGF;
    if (a < 16'h0060) return RG_IO;
    if (a < 16'h0100) return RG_EXT;
    if (a < 16'h0300) return RG_SRAM;
    return RG_NONE;
  endfunction : region_of

  task automatic check_val(logic [15:0] got, logic [15:0] exp, string what);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_val

  task automatic complete_run();
    if (bad_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic hang();
    bad_count++;
    $display("wrong value at %0t: wait ran out", $time);
    complete_run();
  endtask : hang

  task automatic run_op(cit_op_e k, logic [15:0] a, logic [7:0] d, cit_amode_e m = AM_DIRECT,
                        cit_ptr_e p = PTR_X, logic [5:0] s = 6'h00, logic [1:0] x = 2'h0);
    int n;
    n = 0;
    @(negedge ref_clk);
    op = '{k, m, p, x, s, a, d};
    op_valid = 1'b1;
    while (op_ready !== 1'b1) begin
      @(negedge ref_clk);
      n++;
      if (n > 60) hang();
    end
    @(posedge ref_clk);
  endtask : run_op

  task automatic rest(int n);
    repeat (n) begin
      @(negedge ref_clk);
      op_valid = 1'b0;
    end
  endtask : rest

  task automatic wait_ack(int t0, output int lat);
    int n;
    n = 0;
    while (t_ack <= t0 && n < 80) begin
      rest(1);
      n++;
    end
    if (n >= 80) hang();
    lat = t_ack - t0;
  endtask : wait_ack

  task automatic stall_count(output int c);
    c = 0;
    repeat (12) begin
      rest(1);
      if (stalled === 1'b1) c++;
    end
  endtask : stall_count

  // Observes every access and result at the settled half of the cycle
  always @(negedge ref_clk) begin
    if (irq_ack_ff === 1'b1) t_ack = cyc;
    if (sleeping === 1'b1) sleep_seen = 1;
    if (rd_valid_ff === 1'b1) rdq.push_back(rd_data_ff);
    if (dacc_ff.valid === 1'b1) begin
      last_addr = dacc_ff.addr;
      check_val(16'(dacc_ff.region), 16'(region_of(dacc_ff.addr)), "region");
    end
  end

  initial begin
    int l, lm, ls, n;
    logic [15:0] a;
    logic [7:0] d;
    logic [7:0] e;
    logic [7:0] pv [6] = '{8'h50, 8'h01, 8'h00, 8'h02, 8'hC0, 8'h02};
    cit_amode_e tm [8] = '{AM_POSTINC, AM_IND, AM_PREDEC, AM_DISP, AM_DISP, AM_PREDEC,
                           AM_POSTINC, AM_IND};
    cit_ptr_e tp [8] = '{PTR_X, PTR_X, PTR_X, PTR_Y, PTR_Z, PTR_Z, PTR_Y, PTR_Y};
    logic [15:0] te [8] = '{16'h0150, 16'h0151, 16'h0150, 16'h023F, 16'h02FF, 16'h02BF,
                            16'h0200, 16'h0201};
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    for (int i = 0; i < 24; i++) begin
      ext_rdata = 8'(rnd());
      a = SRAM_BASE + 16'(rnd() % 512);
      d = 8'(rnd());
      sram[a] = d;
      run_op(OP_ST, a, d);
      if (i % 2 == 1) a = 16'(rnd() % 768);
      if (a >= 16'h003F && a <= 16'h0042) a = 16'h0010;
      run_op(OP_LD, a, 8'h00);
      rest(3);
      e = (region_of(a) == RG_SRAM) ? sram[a] : ext_rdata;
      check_val(16'(rdq.size()), 16'h0001, "load count");
      if (region_of(a) != RG_SRAM || sram.exists(a)) check_val(16'(rdq[0]), 16'(e), "load");
      rdq.delete();
      a = 16'(rnd() % 31);
      run_op(OP_OUT, a, d);
      rest(2);
      check_val(last_addr, a + IO_BASE, "out address");
    end
    for (int i = 0; i < 6; i++) run_op(OP_ST, 16'h001A + 16'(i), pv[i]);
    for (int i = 0; i < 8; i++) begin
      run_op(OP_LD, 16'h0000, 8'h00, tm[i], tp[i], (tm[i] == AM_DISP) ? 6'h3F : 6'h00);
      rest(3);
      check_val(last_addr, te[i], "pointer address");
    end
    run_op(OP_JMP, 16'h0FFF, 8'h00);
    rest(3);
    check_val(16'(pc_ff), 16'h0FFF, "jump target");
    run_op(OP_SEI, 16'h0000, 8'h00);
    run_op(OP_NOP, 16'h0000, 8'h00);
    rest(2);
    irq_pending = 1'b1;
    wait_ack(cyc, l);
    check_val(16'(l >= 5), 16'h0001, "entry time");
    check_val(16'(pc_ff), 16'(irq_vector), "vector");
    check_val(sp_ff, 16'hFFFE, "push");
    check_val(16'(gie_ff), 16'h0000, "enable on entry");
    run_op(OP_RETI, 16'h0000, 8'h00);
    run_op(OP_MULTI, 16'h0000, 8'h00, AM_DIRECT, PTR_X, 6'h00, 2'h3);
    rest(1);
    wait_ack(cyc, lm);
    check_val(16'(lm), 16'(l + 3), "multi then entry");
    irq_pending = 1'b0;
    run_op(OP_RETI, 16'h0000, 8'h00);
    rest(6);
    check_val({sp_ff[15:1], gie_ff}, 16'h0001, "return state");
    run_op(OP_SLEEP, 16'h0000, 8'h00);
    rest(3);
    check_val(16'(sleeping), 16'h0001, "asleep");
    irq_pending = 1'b1;
    wait_ack(cyc, ls);
    check_val(16'(ls), 16'(l + 4), "wake entry");
    irq_pending = 1'b0;
    run_op(OP_RETI, 16'h0000, 8'h00);
    run_op(OP_CLI, 16'h0000, 8'h00);
    rest(2);
    irq_pending = 1'b1;
    sleep_seen = 0;
    run_op(OP_SEI, 16'h0000, 8'h00);
    run_op(OP_SLEEP, 16'h0000, 8'h00);
    rest(1);
    wait_ack(cyc, ls);
    check_val(16'(sleep_seen), 16'h0001, "sleep before serve");
    irq_pending = 1'b0;
    run_op(OP_CLI, 16'h0000, 8'h00);
    d = 8'(rnd());
    run_op(OP_OUT, 16'(NV_ADRL_IDX), 8'hA5);
    run_op(OP_OUT, 16'(NV_ADRH_IDX), 8'h01);
    run_op(OP_OUT, 16'(NV_DATA_IDX), d);
    run_op(OP_OUT, 16'(NV_CTRL_IDX), 8'h04);
    run_op(OP_OUT, 16'(NV_CTRL_IDX), 8'h02);
    stall_count(n);
    check_val(16'(n), 16'h0002, "write stall");
    check_val(16'(nv_busy), 16'h0001, "write busy");
    n = 0;
    while (nv_busy !== 1'b0 && n < 200) begin
      rest(1);
      n++;
    end
    check_val(16'(n < 200), 16'h0001, "write completes");
    run_op(OP_OUT, 16'(NV_DATA_IDX), ~d);
    run_op(OP_OUT, 16'(NV_CTRL_IDX), 8'h04);
    rest(6);
    run_op(OP_OUT, 16'(NV_CTRL_IDX), 8'h02);
    rest(3);
    check_val(16'(nv_busy), 16'h0000, "late strobe");
    run_op(OP_OUT, 16'(NV_CTRL_IDX), 8'h01);
    stall_count(n);
    check_val(16'(n), 16'h0004, "read stall");
    rdq.delete();
    run_op(OP_IN, 16'(NV_DATA_IDX), 8'h00);
    rest(3);
    check_val(16'(rdq[0]), 16'(d), "stored byte");
    complete_run();
  end
endmodule : cit_core_test

bind cit_core cit_core_assertions #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .op_valid(op_valid), .op(op), .op_ready(op_ready),
  .irq_pending(irq_pending), .irq_vector(irq_vector), .wake_ready(wake_ready),
  .ext_rdata(ext_rdata), .irq_ack_ff(irq_ack_ff), .pc_ff(pc_ff), .sp_ff(sp_ff),
  .gie_ff(gie_ff), .sleeping(sleeping), .stalled(stalled), .dacc_ff(dacc_ff),
  .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff), .nv_busy(nv_busy)
);
